//--- hdl/sss_pkg.sv
package sss_pkg;
	localparam logic [7:0] ADDR_CORE_CTL = 8'h00;
	localparam logic [7:0] ADDR_SUP_CTL  = 8'h04;
	localparam logic [7:0] ADDR_FLAGS    = 8'h08;
	localparam logic [7:0] ADDR_STATUS   = 8'h0c;
	localparam logic [7:0] ADDR_MASK     = 8'h10;
	localparam logic [7:0] ADDR_CFG      = 8'h14;

	localparam int unsigned CTL_EN     = 0;
	localparam int unsigned CTL_KEEP   = 1;
	localparam int unsigned CTL_FP     = 2;
	localparam int unsigned CTL_MON_EN = 3;
	localparam int unsigned CTL_MON_FP = 4;
	localparam int unsigned CTL_AUTO   = 5;
	localparam int unsigned CTL_OVP    = 6;
	localparam logic [6:0] CORE_CTL_MASK = 7'h3f;
	localparam logic [6:0] CORE_CTL_RST  = 7'h03;
	localparam logic [6:0] SUP_CTL_RST   = 7'h03;

	localparam int unsigned FLG_CORE_SETTLE = 0;
	localparam int unsigned FLG_SUP_SETTLE  = 1;
	localparam int unsigned FLG_SLOW_WAKE   = 2;
	localparam int unsigned FLG_DEEP        = 3;
	localparam int unsigned FLG_MODE_LSB    = 8;

	localparam int unsigned EVT_CORE_SUP = 0;
	localparam int unsigned EVT_CORE_MON = 1;
	localparam int unsigned EVT_SUP_SUP  = 2;
	localparam int unsigned EVT_SUP_MON  = 3;
	localparam int unsigned EVT_W        = 4;
	localparam logic [3:0] MASK_RST      = 4'h0;
	localparam int unsigned CFG_CORE_RESET = 0;
	localparam logic CFG_RST = 1'b1;

	localparam int unsigned CLK_PERIOD_NS   = 100;
	localparam int unsigned SETTLE_FULL_NS  = 2000;
	localparam int unsigned SETTLE_NORM_NS  = 150000;
	localparam int unsigned WAKE_FAST_NS    = 2000;
	localparam int unsigned WAKE_SLOW_NS    = 150000;
	localparam int unsigned CNT_W = 11;
	localparam logic [CNT_W-1:0] SETTLE_FULL_CYC =
		CNT_W'((SETTLE_FULL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] SETTLE_NORM_CYC =
		CNT_W'((SETTLE_NORM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] WAKE_FAST_CYC =
		CNT_W'((WAKE_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] WAKE_SLOW_CYC =
		CNT_W'((WAKE_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	typedef enum logic [2:0] {
		SV_OFF    = 3'h1,
		SV_NORMAL = 3'h2,
		SV_FULL   = 3'h4
	} sss_sv_state_t;

	typedef enum logic [2:0] {
		W_RUN   = 3'h1,
		W_SLEEP = 3'h2,
		W_HOLD  = 3'h4
	} sss_wake_state_t;

	// Monitors have no keep bit; callers pass keep high for them
	function automatic sss_sv_state_t sss_decode(input logic en, input logic keep,
		input logic fp, input logic auto_c, input logic deep);
		sss_sv_state_t s;
		s = SV_OFF;
		if (en && !deep)
			s = fp ? SV_FULL : SV_NORMAL;
		else if (en && keep && !auto_c)
			s = fp ? SV_FULL : SV_NORMAL;
		else if (en && keep && fp)
			s = SV_NORMAL;
		return s;
	endfunction : sss_decode
endpackage : sss_pkg

//--- hdl/sss_settle_timer.sv
`timescale 1ns/1ps
module sss_settle_timer (
	input  wire logic sys_clk_in,
	input  wire logic srst_in,
	input  wire logic start_in,
	input  wire logic fast_in,
	output logic      busy_out,
	output logic      expire_out
);
	logic [sss_pkg::CNT_W-1:0] cnt_q;
	logic                      busy_q;
	logic                      expire_q;
	logic                      fast_q;
	logic [sss_pkg::CNT_W-1:0] run_len_q;

	// A new write restarts the window from the top
	always_ff @(posedge sys_clk_in)
	begin
		if (srst_in)
		begin
			cnt_q    <= '0;
			busy_q   <= 1'b0;
			expire_q <= 1'b0;
			fast_q   <= 1'b0;
		end
		else if (start_in)
		begin
			cnt_q    <= (fast_in ? sss_pkg::SETTLE_FULL_CYC : sss_pkg::SETTLE_NORM_CYC) - 1'b1;
			busy_q   <= 1'b1;
			expire_q <= 1'b0;
			fast_q   <= fast_in;
		end
		else
		begin
			expire_q <= busy_q && cnt_q == '0;
			if (busy_q && cnt_q == '0)
				busy_q <= 1'b0;
			else if (busy_q)
				cnt_q <= cnt_q - 1'b1;
		end
	end

	assign busy_out   = busy_q;
	assign expire_out = expire_q;

	always_ff @(posedge sys_clk_in)
	begin
		if (srst_in || start_in)
			run_len_q <= '0;
		else if (busy_q)
			run_len_q <= run_len_q + 1'b1;
	end

	chk_full_window: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		expire_out && fast_q |-> run_len_q == sss_pkg::SETTLE_FULL_CYC)
		else $error("full-performance window length wrong");
	chk_norm_window: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		expire_out && !fast_q |-> run_len_q == sss_pkg::SETTLE_NORM_CYC)
		else $error("normal window length wrong");
endmodule : sss_settle_timer

//--- hdl/sss_supervisor_ctrl.sv
`timescale 1ns/1ps
module sss_supervisor_ctrl (
	input  wire logic        sys_clk_in,
	input  wire logic        srst_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        deep_sleep_in,
	input  wire logic        core_level_ok_in,
	input  wire logic        core_sup_trip_in,
	input  wire logic        core_mon_trip_in,
	input  wire logic        supply_sup_trip_in,
	input  wire logic        supply_mon_trip_in,
	input  wire logic        overvoltage_in,
	output logic [11:0]      mode_out,
	output logic             cpu_hold_out,
	output logic             por_out,
	output logic             irq_out
);
	localparam int unsigned NSYNC = 6;
	localparam int unsigned S_LVL = 0;
	localparam int unsigned S_CSUP = 1;
	localparam int unsigned S_CMON = 2;
	localparam int unsigned S_HSUP = 3;
	localparam int unsigned S_HMON = 4;
	localparam int unsigned S_OVP = 5;

	logic [6:0]             core_ctl_q;
	logic [6:0]             sup_ctl_q;
	logic [3:0]             status_q;
	logic [3:0]             mask_q;
	logic                   cfg_reset_q;
	logic [31:0]            prdata_q;
	logic                   pslverr_q;
	logic [11:0]            mode_q;
	logic                   por_q;
	logic                   deep_q;
	logic [NSYNC-1:0]       raw;
	logic [NSYNC-1:0]       s1_q;
	logic [NSYNC-1:0]       s2_q;
	logic [NSYNC-1:0]       s3_q;
	logic [NSYNC-1:0]       stable_q;
	logic [NSYNC-1:0]       stable_prev_q;
	logic [NSYNC-1:0]       rise;
	sss_pkg::sss_sv_state_t core_sup_st;
	sss_pkg::sss_sv_state_t core_mon_st;
	sss_pkg::sss_sv_state_t sup_sup_st;
	sss_pkg::sss_sv_state_t sup_mon_st;
	sss_pkg::sss_wake_state_t wake_q;
	logic [sss_pkg::CNT_W-1:0] wake_cnt_q;
	logic                   slow_wake;
	logic                   setup;
	logic                   wr;
	logic                   wr_core;
	logic                   wr_sup;
	logic                   core_busy;
	logic                   core_expire;
	logic                   sup_busy;
	logic [3:0]             evt;
	logic [3:0]             clr;
	logic                   level_fail;
	logic                   ovp_trip;
	logic                   core_evt_reset;

	assign raw = {overvoltage_in, supply_mon_trip_in, supply_sup_trip_in,
		core_mon_trip_in, core_sup_trip_in, core_level_ok_in};

	// Comparator outputs are analog and asynchronous
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++)
		begin : g_sync
			always_ff @(posedge sys_clk_in)
			begin
				if (srst_in)
				begin
					s1_q[gi]          <= 1'b0;
					s2_q[gi]          <= 1'b0;
					s3_q[gi]          <= 1'b0;
					stable_q[gi]      <= 1'b0;
					stable_prev_q[gi] <= 1'b0;
				end
				else
				begin
					s1_q[gi] <= raw[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					if (s2_q[gi] == s3_q[gi])
						stable_q[gi] <= s3_q[gi];
					stable_prev_q[gi] <= stable_q[gi];
				end
			end
		end
	endgenerate

	assign rise = stable_q & ~stable_prev_q;

	// Sleep state is same-domain logic from the CPU
	always_ff @(posedge sys_clk_in)
	begin
		if (srst_in)
			deep_q <= 1'b0;
		else
			deep_q <= deep_sleep_in;
	end

	always_comb
	begin
		core_sup_st = sss_pkg::sss_decode(core_ctl_q[sss_pkg::CTL_EN],
			core_ctl_q[sss_pkg::CTL_KEEP], core_ctl_q[sss_pkg::CTL_FP],
			core_ctl_q[sss_pkg::CTL_AUTO], deep_q);
		core_mon_st = sss_pkg::sss_decode(core_ctl_q[sss_pkg::CTL_MON_EN], 1'b1,
			core_ctl_q[sss_pkg::CTL_MON_FP], core_ctl_q[sss_pkg::CTL_AUTO], deep_q);
		sup_sup_st = sss_pkg::sss_decode(sup_ctl_q[sss_pkg::CTL_EN],
			sup_ctl_q[sss_pkg::CTL_KEEP], sup_ctl_q[sss_pkg::CTL_FP],
			sup_ctl_q[sss_pkg::CTL_AUTO], deep_q);
		sup_mon_st = sss_pkg::sss_decode(sup_ctl_q[sss_pkg::CTL_MON_EN], 1'b1,
			sup_ctl_q[sss_pkg::CTL_MON_FP], sup_ctl_q[sss_pkg::CTL_AUTO], deep_q);
		if (sup_ctl_q[sss_pkg::CTL_AUTO] && deep_q)
			sup_mon_st = sss_pkg::SV_OFF;
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (srst_in)
			mode_q <= {sss_pkg::SV_OFF, sss_pkg::SV_OFF, sss_pkg::SV_OFF, sss_pkg::SV_OFF};
		else
			mode_q <= {sup_mon_st, sup_sup_st, core_mon_st, core_sup_st};
	end

	assign mode_out = mode_q;

	// Any enabled core-side block with its CTL_FP or CTL_MON_FP bit clear forces the slow wake
	assign slow_wake = (core_ctl_q[sss_pkg::CTL_EN] && !core_ctl_q[sss_pkg::CTL_FP]) ||
		(core_ctl_q[sss_pkg::CTL_MON_EN] && !core_ctl_q[sss_pkg::CTL_MON_FP]);

	always_ff @(posedge sys_clk_in)
	begin
		if (srst_in)
		begin
			wake_q     <= sss_pkg::W_RUN;
			wake_cnt_q <= '0;
		end
		else
		begin
			case (wake_q)
				sss_pkg::W_RUN:
					if (deep_q)
						wake_q <= sss_pkg::W_SLEEP;
				sss_pkg::W_SLEEP:
					if (!deep_q)
					begin
						wake_q     <= sss_pkg::W_HOLD;
						wake_cnt_q <= (slow_wake ? sss_pkg::WAKE_SLOW_CYC :
							sss_pkg::WAKE_FAST_CYC) - 1'b1;
					end
				sss_pkg::W_HOLD:
					if (wake_cnt_q == '0)
						wake_q <= sss_pkg::W_RUN;
					else
						wake_cnt_q <= wake_cnt_q - 1'b1;
				default:
					wake_q <= sss_pkg::W_RUN;
			endcase
		end
	end

	assign cpu_hold_out = wake_q == sss_pkg::W_HOLD;

	assign setup   = psel_in && !penable_in;
	assign wr      = psel_in && penable_in && pwrite_in;
	assign wr_core = wr && paddr_in == sss_pkg::ADDR_CORE_CTL;
	assign wr_sup  = wr && paddr_in == sss_pkg::ADDR_SUP_CTL;

	// Window length follows the mode being written, not the old one
	sss_settle_timer u_core_settle (
		.sys_clk_in (sys_clk_in),
		.srst_in    (srst_in),
		.start_in   (wr_core),
		.fast_in    (pwdata_in[sss_pkg::CTL_FP]),
		.busy_out   (core_busy),
		.expire_out (core_expire)
	);

	sss_settle_timer u_sup_settle (
		.sys_clk_in (sys_clk_in),
		.srst_in    (srst_in),
		.start_in   (wr_sup),
		.fast_in    (pwdata_in[sss_pkg::CTL_FP]),
		.busy_out   (sup_busy),
		.expire_out ()
	);

	always_ff @(posedge sys_clk_in)
	begin
		if (srst_in)
		begin
			core_ctl_q  <= sss_pkg::CORE_CTL_RST;
			sup_ctl_q   <= sss_pkg::SUP_CTL_RST;
			mask_q      <= sss_pkg::MASK_RST;
			cfg_reset_q <= sss_pkg::CFG_RST;
		end
		else if (wr_core)
			core_ctl_q <= pwdata_in[6:0] & sss_pkg::CORE_CTL_MASK;
		else if (wr_sup)
			sup_ctl_q <= pwdata_in[6:0];
		else if (wr && paddr_in == sss_pkg::ADDR_MASK)
			mask_q <= pwdata_in[3:0];
		else if (wr && paddr_in == sss_pkg::ADDR_CFG)
			cfg_reset_q <= pwdata_in[sss_pkg::CFG_CORE_RESET];
	end

	// Read data is captured in setup so the access phase never waits
	always_ff @(posedge sys_clk_in)
	begin
		if (srst_in)
		begin
			prdata_q  <= '0;
			pslverr_q <= 1'b0;
		end
		else if (setup)
		begin
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
			if (paddr_in == sss_pkg::ADDR_CORE_CTL)
				prdata_q[6:0] <= core_ctl_q;
			else if (paddr_in == sss_pkg::ADDR_SUP_CTL)
				prdata_q[6:0] <= sup_ctl_q;
			else if (paddr_in == sss_pkg::ADDR_FLAGS)
			begin
				prdata_q[sss_pkg::FLG_CORE_SETTLE] <= core_busy;
				prdata_q[sss_pkg::FLG_SUP_SETTLE]  <= sup_busy;
				prdata_q[sss_pkg::FLG_SLOW_WAKE]   <= slow_wake;
				prdata_q[sss_pkg::FLG_DEEP]        <= deep_q;
				prdata_q[sss_pkg::FLG_MODE_LSB +: 12] <= mode_q;
			end
			else if (paddr_in == sss_pkg::ADDR_STATUS)
				prdata_q[3:0] <= status_q;
			else if (paddr_in == sss_pkg::ADDR_MASK)
				prdata_q[3:0] <= mask_q;
			else if (paddr_in == sss_pkg::ADDR_CFG)
				prdata_q[sss_pkg::CFG_CORE_RESET] <= cfg_reset_q;
			else
				pslverr_q <= 1'b1;
		end
	end

	assign pready_out  = psel_in && penable_in;
	assign prdata_out  = prdata_q;
	assign pslverr_out = pslverr_q && psel_in && penable_in;

	// Trips count only while the watching block is powered
	assign evt[sss_pkg::EVT_CORE_SUP] = rise[S_CSUP] && core_sup_st != sss_pkg::SV_OFF;
	assign evt[sss_pkg::EVT_CORE_MON] = rise[S_CMON] && core_mon_st != sss_pkg::SV_OFF;
	assign evt[sss_pkg::EVT_SUP_SUP]  = rise[S_HSUP] && sup_sup_st != sss_pkg::SV_OFF;
	assign evt[sss_pkg::EVT_SUP_MON]  = rise[S_HMON] && sup_mon_st != sss_pkg::SV_OFF;
	assign clr = (wr && paddr_in == sss_pkg::ADDR_STATUS) ? pwdata_in[3:0] : 4'h0;

	assign core_evt_reset = cfg_reset_q &&
		(evt[sss_pkg::EVT_CORE_SUP] || evt[sss_pkg::EVT_CORE_MON]);
	assign level_fail = core_expire && !stable_q[S_LVL] &&
		core_sup_st != sss_pkg::SV_OFF;
	assign ovp_trip = sup_ctl_q[sss_pkg::CTL_OVP] && stable_q[S_OVP] &&
		sup_mon_st != sss_pkg::SV_OFF;

	// Set beats a clear in the same cycle
	always_ff @(posedge sys_clk_in)
	begin
		if (srst_in)
			status_q <= '0;
		else if (cfg_reset_q)
			status_q <= (status_q & ~clr) | {evt[3:2], 2'b00};
		else
			status_q <= (status_q & ~clr) | evt;
	end

	assign irq_out = |(status_q & mask_q);

	always_ff @(posedge sys_clk_in)
	begin
		if (srst_in)
			por_q <= 1'b0;
		else
			por_q <= level_fail || ovp_trip || core_evt_reset;
	end

	assign por_out = por_q;

	chk_level_reset: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		level_fail |=> por_out)
		else $error("missing core level gave no reset");
	chk_settle_flag: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		wr_core && pwdata_in[sss_pkg::CTL_FP] |=> core_busy [*8] ##12 core_busy ##1 !core_busy)
		else $error("core settle flag span wrong");
	chk_fast_wake: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		wake_q == sss_pkg::W_SLEEP && !deep_q && !slow_wake
		|=> cpu_hold_out ##19 cpu_hold_out ##1 !cpu_hold_out)
		else $error("fast wake hold not 2 us");
	chk_slow_wake: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		wake_q == sss_pkg::W_SLEEP && !deep_q && slow_wake
		|=> cpu_hold_out ##299 cpu_hold_out)
		else $error("slow wake released early");
	chk_auto_mon_off: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		sup_ctl_q[sss_pkg::CTL_AUTO] && deep_q && $stable(sup_ctl_q)
		|=> mode_q[11:9] == sss_pkg::SV_OFF)
		else $error("supply monitor active asleep");
	chk_ovp_por: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		ovp_trip |=> por_out)
		else $error("overvoltage gave no reset");
	chk_evt_route: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		rise[S_CSUP] && core_sup_st != sss_pkg::SV_OFF && !cfg_reset_q
		|=> status_q[sss_pkg::EVT_CORE_SUP] && !por_out)
		else $error("core event not routed to interrupt");
	chk_auto_decode: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		core_ctl_q[2:0] == 3'h7 && core_ctl_q[sss_pkg::CTL_AUTO] && deep_q
		|=> mode_q[2:0] == sss_pkg::SV_NORMAL)
		else $error("auto full mode not lowered");
	chk_puc_clear: assert property (@(posedge sys_clk_in)
		srst_in |=> !por_out && !irq_out && !cpu_hold_out)
		else $error("reset did not clear outputs");

	cov_slow_wake: cover property (@(posedge sys_clk_in) disable iff (srst_in)
		wake_q == sss_pkg::W_SLEEP ##1 cpu_hold_out && slow_wake);
	cov_level_por: cover property (@(posedge sys_clk_in) disable iff (srst_in)
		level_fail ##1 por_out);
	cov_irq: cover property (@(posedge sys_clk_in) disable iff (srst_in)
		$rose(irq_out));
endmodule : sss_supervisor_ctrl

//--- tb/supply_supervisor_mode_control_bench.sv
`timescale 1ns/1ps
module supply_supervisor_mode_control_bench;
	logic        sys_clk_in;
	logic        srst_in;
	logic        psel_in;
	logic        penable_in;
	logic        pwrite_in;
	logic [7:0]  paddr_in;
	logic [31:0] pwdata_in;
	logic [31:0] prdata_out;
	logic        pready_out;
	logic        pslverr_out;
	logic        deep_sleep_in;
	logic        core_level_ok_in;
	logic        core_sup_trip_in;
	logic        core_mon_trip_in;
	logic        supply_sup_trip_in;
	logic        supply_mon_trip_in;
	logic        overvoltage_in;
	logic [11:0] mode_out;
	logic        cpu_hold_out;
	logic        por_out;
	logic        irq_out;
	int          err_total;
	int          tests_run;
	int          cyc;
	int          por_cnt;
	logic [6:0]  t_core [8];
	logic [6:0]  t_sup [8];
	logic [11:0] t_act [8];
	logic [11:0] t_deep [8];
	logic [7:0]  t_slow;
	logic [31:0] d;
	logic        e;
	int          p0;
	int          n;

	sss_supervisor_ctrl dut (
		.sys_clk_in(sys_clk_in), .srst_in(srst_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .deep_sleep_in(deep_sleep_in),
		.core_level_ok_in(core_level_ok_in), .core_sup_trip_in(core_sup_trip_in),
		.core_mon_trip_in(core_mon_trip_in), .supply_sup_trip_in(supply_sup_trip_in),
		.supply_mon_trip_in(supply_mon_trip_in), .overvoltage_in(overvoltage_in),
		.mode_out(mode_out), .cpu_hold_out(cpu_hold_out), .por_out(por_out),
		.irq_out(irq_out)
	);

	initial
	begin
		sys_clk_in = 1'b0;
		forever #50 sys_clk_in = ~sys_clk_in;
	end

	// Event resets pulse for one cycle and overvoltage holds por_out high, so count high cycles as they pass
	always @(posedge sys_clk_in)
	begin
		cyc <= cyc + 1;
		if (por_out === 1'b1)
			por_cnt <= por_cnt + 1;
	end

	task wrap_up;
		if (err_total == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			$display("unexpected %s expected %h seen %h", name, exp, got);
			err_total++;
		end
	endtask : chk

	task timed_out(input string name);
		$display("unexpected %s expected done seen timeout", name);
		err_total++;
		wrap_up();
	endtask : timed_out

	task tick(input int k);
		repeat (k) @(posedge sys_clk_in);
	endtask : tick

	task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int w;
		@(posedge sys_clk_in);
		psel_in    <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in  <= wr;
		paddr_in   <= a;
		pwdata_in  <= wd;
		@(posedge sys_clk_in);
		penable_in <= 1'b1;
		w = 0;
		do
		begin
			@(posedge sys_clk_in);
			w++;
		end
		while (pready_out !== 1'b1 && w < 16);
		if (pready_out !== 1'b1)
			timed_out("pready");
		rd = prdata_out;
		err = pslverr_out;
		psel_in    <= 1'b0;
		penable_in <= 1'b0;
	endtask : xfer

	task wr(input logic [7:0] a, input logic [31:0] wd);
		xfer(1'b1, a, wd, d, e);
		chk("write pslverr", 32'h0, e);
	endtask : wr

	task rd(input logic [7:0] a);
		xfer(1'b0, a, 32'h0, d, e);
	endtask : rd

	// Software side must see both settle flags clear before sleeping
	task wait_idle;
		int k;
		k = 0;
		do
		begin
			rd(sss_pkg::ADDR_FLAGS);
			k++;
		end
		while (d[1:0] !== 2'h0 && k < 800);
		if (d[1:0] !== 2'h0)
			timed_out("settle flags");
	endtask : wait_idle

	// Read polling gives a few cycles of slack on the window end
	task settle_time(input logic [6:0] ctl, input int exp);
		int t0;
		wr(sss_pkg::ADDR_CORE_CTL, {25'h0, ctl});
		t0 = cyc;
		rd(sss_pkg::ADDR_FLAGS);
		chk("core settle flag", 32'h1, d[0]);
		wait_idle();
		chk("settle window", 32'h1, (cyc - t0 >= exp) && (cyc - t0 <= exp + 8));
	endtask : settle_time

	initial
	begin
		srst_in = 1'b1;
		psel_in = 1'b0;
		penable_in = 1'b0;
		pwrite_in = 1'b0;
		paddr_in = 8'h00;
		pwdata_in = 32'h0;
		deep_sleep_in = 1'b0;
		core_level_ok_in = 1'b1;
		core_sup_trip_in = 1'b0;
		core_mon_trip_in = 1'b0;
		supply_sup_trip_in = 1'b0;
		supply_mon_trip_in = 1'b0;
		overvoltage_in = 1'b0;
		err_total = 0;
		tests_run = 0;
		cyc = 0;
		por_cnt = 0;
		t_core = '{7'h00, 7'h01, 7'h05, 7'h0b, 7'h07, 7'h23, 7'h3f, 7'h19};
		t_sup = '{7'h03, 7'h03, 7'h03, 7'h0b, 7'h03, 7'h03, 7'h2b, 7'h3f};
		t_act = '{12'h289, 12'h28a, 12'h28c, 12'h492, 12'h28c, 12'h28a, 12'h4a4, 12'h922};
		t_deep = '{12'h289, 12'h289, 12'h289, 12'h492, 12'h28c, 12'h289, 12'h252, 12'h2a1};
		t_slow = 8'haa;
		tick(12);
		srst_in <= 1'b0;
		for (int r = 0; r < 2; r++)
		begin
			rd(sss_pkg::ADDR_CORE_CTL);
			chk("core ctl reset", 32'h3, d);
			rd(sss_pkg::ADDR_SUP_CTL);
			chk("supply ctl reset", 32'h3, d);
			rd(sss_pkg::ADDR_MASK);
			chk("mask reset", 32'h0, d);
			rd(sss_pkg::ADDR_CFG);
			chk("cfg reset", 32'h1, d);
			rd(sss_pkg::ADDR_FLAGS);
			chk("flags reset", 32'h28a04, d);
			wr(sss_pkg::ADDR_CORE_CTL, 32'h27);
			wr(sss_pkg::ADDR_CFG, 32'h0);
			srst_in <= 1'b1;
			tick(2);
			srst_in <= 1'b0;
		end
		xfer(1'b1, 8'h1c, 32'hffff_ffff, d, e);
		chk("unmapped write err", 32'h1, e);
		xfer(1'b0, 8'h1c, 32'h0, d, e);
		chk("unmapped read err", 32'h1, e);
		chk("unmapped read data", 32'h0, d);
		wait_idle();
		settle_time(7'h07, 20);
		settle_time(7'h03, 1500);
		for (int i = 0; i < 8; i++)
		begin
			wr(sss_pkg::ADDR_CORE_CTL, {25'h0, t_core[i]});
			wr(sss_pkg::ADDR_SUP_CTL, {25'h0, t_sup[i]});
			rd(sss_pkg::ADDR_FLAGS);
			chk("both settle flags", 32'h3, d[1:0]);
			wait_idle();
			chk("slow wake flag", t_slow[i], d[2]);
			chk("active modes", t_act[i], mode_out);
			deep_sleep_in <= 1'b1;
			tick(6);
			chk("sleep modes", t_deep[i], mode_out);
			deep_sleep_in <= 1'b0;
			n = 0;
			while (cpu_hold_out !== 1'b1 && n < 10)
			begin
				tick(1);
				n++;
			end
			n = 0;
			while (cpu_hold_out === 1'b1 && n < 1700)
			begin
				tick(1);
				n++;
			end
			chk("wake hold", t_slow[i] ? 32'd1500 : 32'd20, n);
		end
		core_level_ok_in <= 1'b0;
		tick(8);
		p0 = por_cnt;
		wr(sss_pkg::ADDR_CORE_CTL, 32'h0b);
		wr(sss_pkg::ADDR_SUP_CTL, 32'h0b);
		wait_idle();
		tick(4);
		chk("late level reset", p0 + 1, por_cnt);
		core_level_ok_in <= 1'b1;
		wr(sss_pkg::ADDR_CFG, 32'h0);
		core_sup_trip_in <= 1'b1;
		core_mon_trip_in <= 1'b1;
		tick(8);
		rd(sss_pkg::ADDR_STATUS);
		chk("core events", 32'h3, d);
		chk("irq masked", 32'h0, irq_out);
		wr(sss_pkg::ADDR_MASK, 32'h1);
		tick(1);
		chk("irq unmasked", 32'h1, irq_out);
		// Service routine delay must not lose the pending level
		tick(sss_pkg::WAKE_SLOW_CYC);
		chk("irq held", 32'h1, irq_out);
		core_sup_trip_in <= 1'b0;
		core_mon_trip_in <= 1'b0;
		wr(sss_pkg::ADDR_STATUS, 32'h3);
		tick(1);
		chk("irq cleared", 32'h0, irq_out);
		wr(sss_pkg::ADDR_CFG, 32'h1);
		p0 = por_cnt;
		core_sup_trip_in <= 1'b1;
		supply_sup_trip_in <= 1'b1;
		supply_mon_trip_in <= 1'b1;
		tick(8);
		chk("core event reset", p0 + 1, por_cnt);
		rd(sss_pkg::ADDR_STATUS);
		chk("supply events", 32'hc, d);
		wr(sss_pkg::ADDR_MASK, 32'h8);
		tick(1);
		chk("irq supply", 32'h1, irq_out);
		wr(sss_pkg::ADDR_STATUS, 32'hc);
		rd(sss_pkg::ADDR_STATUS);
		chk("status cleared", 32'h0, d);
		core_sup_trip_in <= 1'b0;
		supply_sup_trip_in <= 1'b0;
		supply_mon_trip_in <= 1'b0;
		for (int v = 0; v < 2; v++)
		begin
			wr(sss_pkg::ADDR_SUP_CTL, v ? 32'h0b : 32'h4b);
			wait_idle();
			p0 = por_cnt;
			overvoltage_in <= 1'b1;
			tick(10);
			overvoltage_in <= 1'b0;
			tick(8);
			chk("overvoltage reset", v ? 32'h0 : 32'h1, por_cnt - p0 >= (v ? 1 : 4));
		end
		wrap_up();
	end

	initial
	begin
		tick(95000);
		timed_out("run length");
	end
endmodule : supply_supervisor_mode_control_bench
